// ===== rtl/eivs_ext_irq.sv
// top module: external pin irq, pin-change groups and vector placement
`timescale 1ns/1ps
`default_nettype none
module eivs_ext_irq
  import eivs_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins, read at the pad whatever their direction
  input wire logic ext_irq_pin_zero,
  input wire logic [EIVS_NPC-1:0] pin_change_inputs,
  // core side
  input wire logic global_irq_enable,
  input wire logic insn_done,
  input wire logic exec_in_boot_area,
  input wire logic boot_lock_app_side,
  input wire logic boot_lock_boot_side,
  input wire logic [15:0] boot_area_base,
  input wire logic [EIVS_NGRP:0] irq_ack,
  // towards the core
  output var eivs_req_s irq_req,
  output logic irq_blocked,
  output logic [15:0] vector_base,
  // asynchronous wake-up, no clock needed
  output logic wake_request
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic vts_q, vce_q;
  logic [1:0] sense_q;
  logic pin_en_q;
  logic [EIVS_NGRP-1:0] grp_en_q, grp_flag_q;
  logic pin_flag_q;
  logic [7:0] mask_q [EIVS_NGRP];
  logic [2:0] arm_cnt_q;
  eivs_arm_e arm_q;
  logic pin_s1_q, pin_s2_q, pin_s3_q;
  logic [EIVS_NPC-1:0] pc_s1_q, pc_s2_q, pc_s3_q;
  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire wr_en = psel && penable && pwrite && pstrb[0];
  wire sel_vpc = paddr == EIVS_VPC_OFF;
  wire sel_sense = paddr == EIVS_SENSE_OFF;
  wire sel_en = paddr == EIVS_EN_OFF;
  wire sel_flag = paddr == EIVS_FLAG_OFF;
  wire [3:0] sel_mask = {paddr == EIVS_MASK3_OFF, paddr == EIVS_MASK2_OFF,
                         paddr == EIVS_MASK1_OFF, paddr == EIVS_MASK0_OFF};
  wire mapped = sel_vpc | sel_sense | sel_en | sel_flag | (|sel_mask);
  wire wr_vpc = wr_en && sel_vpc;
  wire vce_wr1 = wr_vpc && pwdata[EIVS_VCE_BIT];
  // select write only counts while armed and with zero in the arm bit
  wire vts_commit = wr_vpc && vce_q && !pwdata[EIVS_VCE_BIT]; // [RQ1] [RQ7]
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [7:0] flag_rd = {grp_flag_q, 3'h0, pin_flag_q};
  wire [7:0] en_rd = {grp_en_q, 3'h0, pin_en_q};
  wire [7:0] vpc_rd = {6'h00, vts_q, vce_q};
  wire [7:0] rd_byte = sel_vpc ? vpc_rd :
                       sel_sense ? {6'h00, sense_q} :
                       sel_en ? en_rd :
                       sel_flag ? flag_rd :
                       sel_mask[0] ? mask_q[0] :
                       sel_mask[1] ? mask_q[1] :
                       sel_mask[2] ? mask_q[2] :
                       sel_mask[3] ? (mask_q[3] & EIVS_MASK3_VALID) : EIVS_RST8;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else prdata <= {24'h00_0000, rd_byte};
  end
  // ----------------------------------------------------------------
  // vector change sequence
  // ----------------------------------------------------------------
  eivs_arm_e arm_d;
  logic [2:0] arm_cnt_d;
  always_comb begin
    arm_d = arm_q;
    arm_cnt_d = arm_cnt_q;
    case (arm_q)
      EIVS_ST_IDLE: begin
        if (vce_wr1) begin
          arm_d = EIVS_ST_ARMED;
          arm_cnt_d = EIVS_ARM_CNT - 3'h1;
        end
      end
      EIVS_ST_ARMED: begin
        if (vts_commit) arm_d = EIVS_ST_TRAIL;
        else if (arm_cnt_q == 3'h1) arm_d = EIVS_ST_IDLE; // [RQ4] [RQ3]
        else arm_cnt_d = arm_cnt_q - 3'h1;
      end
      // hold off until the instruction after the select write retires
      EIVS_ST_TRAIL: begin
        if (insn_done) arm_d = EIVS_ST_IDLE; // [RQ2]
      end
      default: arm_d = EIVS_ST_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_q <= EIVS_ST_IDLE;
      arm_cnt_q <= 3'h0;
      vce_q <= 1'b0;
      vts_q <= 1'b0;
    end else begin
      arm_q <= arm_d;
      arm_cnt_q <= arm_cnt_d;
      vce_q <= arm_d == EIVS_ST_ARMED; // [RQ4] [RQ7]
      if (vts_commit) vts_q <= pwdata[EIVS_VTS_BIT]; // [RQ1]
    end
  end
  // blocking starts in the cycle the arm bit is written; global enable untouched
  wire seq_block = vce_wr1 || arm_q != EIVS_ST_IDLE; // [RQ2] [RQ3]
  wire lock_block = (vts_q && boot_lock_app_side && !exec_in_boot_area) ||
                    (!vts_q && boot_lock_boot_side && exec_in_boot_area); // [RQ5]
  assign irq_blocked = seq_block || lock_block;
  assign vector_base = vts_q ? boot_area_base : 16'h0000; // [RQ6]
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_q <= 2'h0;
      pin_en_q <= 1'b0;
      grp_en_q <= 4'h0;
    end else begin
      if (wr_en && sel_sense) sense_q <= pwdata[1:0]; // [RQ11]
      if (wr_en && sel_en) begin
        pin_en_q <= pwdata[EIVS_PIN_EN_BIT];
        grp_en_q <= pwdata[EIVS_GRP_EN_LSB +: EIVS_NGRP];
      end
    end
  end
  // ----------------------------------------------------------------
  // pin sampling: two flops then an edge stage
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
      pc_s1_q <= '0;
      pc_s2_q <= '0;
      pc_s3_q <= '0;
    end else begin
      pin_s1_q <= ext_irq_pin_zero; // [RQ26] [RQ15]
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pc_s1_q <= pin_change_inputs; // [RQ26]
      pc_s2_q <= pc_s1_q;
      pc_s3_q <= pc_s2_q;
    end
  end
  wire pin_rise = pin_s2_q && !pin_s3_q;
  wire pin_fall = !pin_s2_q && pin_s3_q;
  wire sense_low = sense_q == EIVS_SENSE_LOW;
  wire pin_edge = (sense_q == EIVS_SENSE_ANY && (pin_rise || pin_fall)) ||
                  (sense_q == EIVS_SENSE_FALL && pin_fall) ||
                  (sense_q == EIVS_SENSE_RISE && pin_rise); // [RQ11] [RQ13]
  wire [EIVS_NPC-1:0] pc_toggle = pc_s2_q ^ pc_s3_q;
  // group membership; a mask bit counts only with its group enable
  logic [EIVS_NGRP-1:0] grp_hit;
  genvar g;
  generate
    for (g = 0; g < EIVS_NGRP; g++) begin : g_grp
      localparam int W = (g == EIVS_NGRP - 1) ? 7 : 8;
      assign grp_hit[g] = grp_en_q[g] &&
        |(pc_toggle[g*8 +: W] & mask_q[g][W-1:0]); // [RQ9] [RQ18] [RQ19] [RQ20] [RQ21] [RQ25]
    end
  endgenerate
  // ----------------------------------------------------------------
  // mask registers and flags; set wins over clear
  // ----------------------------------------------------------------
  wire flag_wr = wr_en && sel_flag;
  wire pin_clr = (flag_wr && pwdata[0]) || irq_ack[0];
  wire [EIVS_NGRP-1:0] grp_clr = (flag_wr ? pwdata[7:4] : 4'h0) | irq_ack[EIVS_NGRP:1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < EIVS_NGRP; i++) mask_q[i] <= EIVS_RST8;
      pin_flag_q <= 1'b0;
      grp_flag_q <= 4'h0;
    end else begin
      for (int i = 0; i < EIVS_NGRP; i++) if (wr_en && sel_mask[i]) mask_q[i] <= pwdata[7:0];
      if (sense_low) pin_flag_q <= 1'b0; // [RQ24]
      else if (pin_edge) pin_flag_q <= 1'b1; // [RQ23] [RQ8]
      else if (pin_clr) pin_flag_q <= 1'b0; // [RQ23]
      grp_flag_q <= grp_hit | (grp_flag_q & ~grp_clr); // [RQ23]
    end
  end
  // ----------------------------------------------------------------
  // requests towards the core
  // ----------------------------------------------------------------
  wire gate = global_irq_enable && !irq_blocked; // [RQ17]
  wire pin_level = sense_low && !pin_s2_q; // [RQ12] [RQ16]
  assign irq_req.pin_req = gate && pin_en_q && (pin_level || pin_flag_q); // [RQ22] [RQ17]
  assign irq_req.grp_req = gate ? (grp_en_q & grp_flag_q) : 4'h0; // [RQ18] [RQ21]
  // wake path is pure logic; a level gone before start-up ends raises nothing
  wire [EIVS_NPC-1:0] async_mask = {mask_q[3][6:0], mask_q[2], mask_q[1], mask_q[0]};
  wire [EIVS_NPC-1:0] grp_mask_x = {{7{grp_en_q[3]}}, {8{grp_en_q[2]}},
                                   {8{grp_en_q[1]}}, {8{grp_en_q[0]}}};
  assign wake_request = (pin_en_q && sense_low && !ext_irq_pin_zero) ||
    |((pin_change_inputs ^ pc_s2_q) & async_mask & grp_mask_x); // [RQ10] [RQ13] [RQ14]
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  arm_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(vce_q) && !vts_commit |-> ##[1:4] !vce_q) // [RQ4]
    else $error("arm bit not cleared in four cycles");
  arm_blocks_a: assert property (@(posedge pclk) disable iff (!presetn)
    vce_q |-> irq_blocked) // [RQ2]
    else $error("interrupts not blocked while armed");
  sel_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(vts_commit) |-> vts_q == $past(vts_q)) // [RQ1]
    else $error("select changed without sequence");
  low_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(sense_low) && sense_low |-> !pin_flag_q) // [RQ24]
    else $error("pin flag set in low-level mode");
  gie_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !global_irq_enable |-> irq_req == '0) // [RQ17]
    else $error("request without global enable");
  grp_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    grp_hit[0] |=> grp_flag_q[0]) // [RQ23]
    else $error("group flag missed a change");
  fall_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    sense_q == EIVS_SENSE_FALL && $fell(pin_s2_q) && $stable(sense_q) |=> pin_flag_q) // [RQ11]
    else $error("falling edge not flagged");
  vec_base_a: assert property (@(posedge pclk) disable iff (!presetn)
    vts_commit |=> vector_base == ($past(pwdata[EIVS_VTS_BIT]) ? boot_area_base : 16'h0000)) // [RQ6]
    else $error("vector base wrong");
  lock_blk_a: assert property (@(posedge pclk) disable iff (!presetn)
    vts_q && boot_lock_app_side && !exec_in_boot_area |-> irq_blocked) // [RQ5]
    else $error("lock block missing");
  move_c: cover property (@(posedge pclk) disable iff (!presetn) vts_commit);
  expire_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(vce_q) && !vts_q);
  pin_c: cover property (@(posedge pclk) disable iff (!presetn) irq_req.pin_req);
  grp_c: cover property (@(posedge pclk) disable iff (!presetn) irq_req.grp_req[3]);
endmodule
`default_nettype wire

// ===== rtl/eivs_pkg.sv
// package: register map, field positions and timing for the external irq block
//
// Notes on behaviour
// [RQ1] arm then write select within four cycles
// [RQ2] block interrupts from arm through next instruction
// [RQ3] unwritten arm blocks four cycles, keeps global enable
// [RQ4] arm clears after four cycles or select write
// [RQ5] boot lock blocks interrupts from other area
// [RQ6] select bit one moves vectors to boot
// [RQ7] arm bit at position zero, only arming way
// [RQ8] pins fire even when driven as outputs
// [RQ9] group one watches 15:8, group zero 7:0
// [RQ10] pin changes detected without the clock
// [RQ11] sense field: low, change, fall, rise
// [RQ12] low level requests while pin low
// [RQ13] edges clocked, low level detected asynchronously
// [RQ14] wake level must last through start-up
// [RQ15] pin sampled, pulses over one period caught
// [RQ16] source holds low through current instruction
// [RQ17] pin irq needs global and own enable
// [RQ18] enable bit 7 gates group 3, inputs 30:24
// [RQ19] enable bit 6 gates group 2, inputs 23:16
// [RQ20] enable bit 5 gates group 1, inputs 15:8
// [RQ21] enable bit 4 gates group 0, inputs 7:0
// [RQ22] enable bit 0 gates pin irq per sense
// [RQ23] flags set on request, clear on service or one
// [RQ24] pin flag held clear in low-level mode
// [RQ25] mask bit counts only with group enable
// [RQ26] pins synchronised twice before edge detection
package eivs_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] EIVS_VPC_OFF = 12'h000;
  localparam logic [11:0] EIVS_SENSE_OFF = 12'h004;
  localparam logic [11:0] EIVS_EN_OFF = 12'h008;
  localparam logic [11:0] EIVS_FLAG_OFF = 12'h00c;
  localparam logic [11:0] EIVS_MASK0_OFF = 12'h010;
  localparam logic [11:0] EIVS_MASK1_OFF = 12'h014;
  localparam logic [11:0] EIVS_MASK2_OFF = 12'h018;
  localparam logic [11:0] EIVS_MASK3_OFF = 12'h01c;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int EIVS_VCE_BIT = 0;
  localparam int EIVS_VTS_BIT = 1;
  localparam int EIVS_PIN_EN_BIT = 0;
  localparam int EIVS_GRP_EN_LSB = 4;
  localparam int EIVS_NGRP = 4;
  localparam int EIVS_NPC = 31;
  localparam logic [7:0] EIVS_RST8 = 8'h00;
  localparam logic [7:0] EIVS_MASK3_VALID = 8'h7f;
  // ----------------------------------------------------------------
  // timing: arm window is four core cycles
  // ----------------------------------------------------------------
  localparam int EIVS_ARM_CYCLES = 4;
  localparam logic [2:0] EIVS_ARM_CNT = 3'(EIVS_ARM_CYCLES);
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EIVS_SENSE_LOW = 2'h0,
    EIVS_SENSE_ANY = 2'h1,
    EIVS_SENSE_FALL = 2'h2,
    EIVS_SENSE_RISE = 2'h3
  } eivs_sense_e;
  typedef enum logic [2:0] {
    EIVS_ST_IDLE = 3'h1,
    EIVS_ST_ARMED = 3'h2,
    EIVS_ST_TRAIL = 3'h4
  } eivs_arm_e;
  typedef struct packed {
    logic pin_req;
    logic [EIVS_NGRP-1:0] grp_req;
  } eivs_req_s;
endpackage

// ===== verif/eivs_pin_model.sv
// partner model: drivers of the external irq pin and the pin-change pins
`timescale 1ns/1ps
`default_nettype none
module eivs_pin_model
  import eivs_pkg::*;
(
  // clock
  input wire logic pclk,
  // pins, always driven push-pull
  output logic ext_irq_pin_zero,
  output logic [EIVS_NPC-1:0] pin_change_inputs
);
  initial begin
    ext_irq_pin_zero = 1'b1;
    pin_change_inputs = {EIVS_NPC{1'b0}};
  end
  // a level stays until the next call, so it outlasts a clock and an instruction
  task automatic set_pin(input logic level);
    @(posedge pclk);
    ext_irq_pin_zero <= level;
  endtask
  task automatic toggle_pc(input int idx);
    @(posedge pclk);
    pin_change_inputs[idx] <= ~pin_change_inputs[idx];
  endtask
endmodule
`default_nettype wire

// ===== verif/ext_irq_and_vector_select_test.sv
// testbench: apb register sequences against pin and vector behaviour
`timescale 1ns/1ps
`default_nettype none
`define EIVS_CHK(act, exp) begin checks++; if ((act) !== (exp)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (act), (exp)); end end
module ext_irq_and_vector_select_test
  import eivs_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic ext_irq_pin_zero, global_irq_enable, insn_done, exec_in_boot_area;
  logic [EIVS_NPC-1:0] pin_change_inputs;
  logic boot_lock_app_side, boot_lock_boot_side, irq_blocked, wake_request;
  logic [15:0] boot_area_base, vector_base;
  logic [EIVS_NGRP:0] irq_ack;
  eivs_req_s irq_req;
  int mismatches, checks;
  logic [7:0] lo_exp [4] = '{8'h00, 8'h01, 8'h01, 8'h00};
  logic [7:0] hi_exp [4] = '{8'h00, 8'h01, 8'h00, 8'h01};

  eivs_ext_irq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_irq_pin_zero(ext_irq_pin_zero),
    .pin_change_inputs(pin_change_inputs), .global_irq_enable(global_irq_enable),
    .insn_done(insn_done), .exec_in_boot_area(exec_in_boot_area),
    .boot_lock_app_side(boot_lock_app_side), .boot_lock_boot_side(boot_lock_boot_side),
    .boot_area_base(boot_area_base), .irq_ack(irq_ack), .irq_req(irq_req),
    .irq_blocked(irq_blocked), .vector_base(vector_base), .wake_request(wake_request));
  eivs_pin_model pins (.pclk(pclk), .ext_irq_pin_zero(ext_irq_pin_zero),
    .pin_change_inputs(pin_change_inputs));

  // ----------------------------------------------------------------
  // apb master and helpers
  // ----------------------------------------------------------------
  task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                          input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // no fixed latency assumed; only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb_xfer(1'b1, a, d, 4'hf);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    apb_xfer(1'b0, a, 8'h00, 4'hf);
    `EIVS_CHK(rd, {24'h000000, exp})
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic insn_pulse();
    @(posedge pclk);
    insn_done <= 1'b1;
    @(posedge pclk);
    insn_done <= 1'b0;
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    cyc(20000);
    mismatches++;
    complete_run();
  end
  initial begin
    {presetn, psel, penable, pwrite, insn_done, exec_in_boot_area} = 6'h00;
    {boot_lock_app_side, boot_lock_boot_side} = 2'h0;
    {paddr, pwdata, pstrb, irq_ack} = {12'h000, 32'h00000000, 4'hf, 5'h00};
    global_irq_enable = 1'b1;
    boot_area_base = 16'h3800;
    cyc(20);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_chk(12'(4 * i), 8'h00);
    end
    apb_xfer(1'b0, 12'h020, 8'h00, 4'hf);
    `EIVS_CHK({er, rd}, {1'b1, 32'h00000000})
    wr(EIVS_MASK3_OFF, 8'hff);
    rd_chk(EIVS_MASK3_OFF, 8'h7f);
    apb_xfer(1'b1, EIVS_MASK1_OFF, 8'h55, 4'h0);
    rd_chk(EIVS_MASK1_OFF, 8'h00);
    // select write without arming must be ignored
    wr(EIVS_VPC_OFF, 8'h02);
    rd_chk(EIVS_VPC_OFF, 8'h00);
    wr(EIVS_VPC_OFF, 8'h01);
    @(negedge pclk);
    `EIVS_CHK(irq_blocked, 1'b1)
    wr(EIVS_VPC_OFF, 8'h02);
    @(negedge pclk);
    `EIVS_CHK({irq_blocked, vector_base}, {1'b1, boot_area_base})
    insn_pulse();
    @(negedge pclk);
    `EIVS_CHK(irq_blocked, 1'b0)
    rd_chk(EIVS_VPC_OFF, 8'h02);
    wr(EIVS_VPC_OFF, 8'h03);
    cyc(6);
    @(negedge pclk);
    `EIVS_CHK(irq_blocked, 1'b0)
    rd_chk(EIVS_VPC_OFF, 8'h02);
    wr(EIVS_VPC_OFF, 8'h00);
    rd_chk(EIVS_VPC_OFF, 8'h02);
    @(posedge pclk);
    boot_lock_app_side <= 1'b1;
    @(negedge pclk);
    `EIVS_CHK(irq_blocked, 1'b1)
    @(posedge pclk);
    exec_in_boot_area <= 1'b1;
    @(negedge pclk);
    `EIVS_CHK(irq_blocked, 1'b0)
    wr(EIVS_VPC_OFF, 8'h03);
    wr(EIVS_VPC_OFF, 8'h00);
    insn_pulse();
    boot_lock_boot_side <= 1'b1;
    @(negedge pclk);
    `EIVS_CHK({irq_blocked, vector_base}, {1'b1, 16'h0000})
    @(posedge pclk);
    {exec_in_boot_area, boot_lock_app_side, boot_lock_boot_side} <= 3'h0;
    // ----------------------------------------------------------------
    // sense modes: low half then high half of a long pulse
    // ----------------------------------------------------------------
    wr(EIVS_EN_OFF, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wr(EIVS_SENSE_OFF, 8'(m));
      pins.set_pin(1'b0);
      cyc(5);
      rd_chk(EIVS_FLAG_OFF, lo_exp[m]);
      @(negedge pclk);
      `EIVS_CHK(irq_req.pin_req, 1'((m == 0) || lo_exp[m][0]))
      if (m == 0) begin
        `EIVS_CHK(wake_request, 1'b1)
        @(posedge pclk);
        global_irq_enable <= 1'b0;
        @(negedge pclk);
        `EIVS_CHK(irq_req.pin_req, 1'b0)
        @(posedge pclk);
        global_irq_enable <= 1'b1;
      end
      wr(EIVS_FLAG_OFF, 8'h01);
      rd_chk(EIVS_FLAG_OFF, 8'h00);
      pins.set_pin(1'b1);
      cyc(5);
      rd_chk(EIVS_FLAG_OFF, hi_exp[m]);
      wr(EIVS_FLAG_OFF, 8'h01);
    end
    // ----------------------------------------------------------------
    // pin-change groups: unmasked pin ignored, masked pin flags
    // ----------------------------------------------------------------
    for (int g = 0; g < 4; g++) begin
      wr(12'(EIVS_MASK0_OFF + 4 * g), 8'h02);
      wr(EIVS_EN_OFF, 8'(8'h10 << g));
      pins.toggle_pc(8 * g + 2);
      cyc(5);
      rd_chk(EIVS_FLAG_OFF, 8'h00);
      pins.toggle_pc(8 * g + 1);
      cyc(5);
      rd_chk(EIVS_FLAG_OFF, 8'(8'h10 << g));
      @(negedge pclk);
      `EIVS_CHK(irq_req.grp_req, 4'(4'h1 << g))
      @(posedge pclk);
      irq_ack[g + 1] <= 1'b1;
      @(posedge pclk);
      irq_ack <= 5'h00;
      rd_chk(EIVS_FLAG_OFF, 8'h00);
    end
    wr(EIVS_EN_OFF, 8'h00);
    pins.toggle_pc(1);
    cyc(5);
    rd_chk(EIVS_FLAG_OFF, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
